// ==== core/lcdc_defines.svh ====
`ifndef LCDC_DEFINES_SVH
`define LCDC_DEFINES_SVH

// Command codes.
`define LCDC_CMD_DISP_OFF    8'h58
`define LCDC_CMD_DISP_ON     8'h59
`define LCDC_CMD_CSR_ADDR    8'h46
`define LCDC_CMD_CURSOR_SHAPE_COMMAND    8'h5D
`define LCDC_CMD_DIR_MASK    8'hFC
`define LCDC_CMD_DIR_BASE    8'h4C
`define LCDC_CMD_MEM_WRITE   8'h42

// Register indices as the command set addresses them.
`define LCDC_REG_DISP_EN     8'h09
`define LCDC_REG_ATTR        8'h0A
`define LCDC_REG_CSR_WIDTH   8'h15
`define LCDC_REG_CSR_HEIGHT  8'h16
`define LCDC_REG_CURSOR_DIRECTION_COMMAND     8'h17
`define LCDC_REG_CSR_LOW     8'h1C
`define LCDC_REG_CSR_HIGH    8'h1D

// Field positions.
`define LCDC_DISP_EN_BIT     0
`define LCDC_FLASH_LSB       0
`define LCDC_BLK1_LSB        2
`define LCDC_BLK24_LSB       4
`define LCDC_BLK3_LSB        6
`define LCDC_SHAPE_BIT       7

// Reset values.
`define LCDC_RESET_BYTE      8'h00
`define LCDC_RESET_ADDR      16'h0000

// Address step for vertical cursor moves, one display line of memory.
`define LCDC_ROW_PITCH       16'h0080

// Cursor flash timing: 2 Hz blink, half period in milliseconds.
`define LCDC_CLK_KHZ         20000
`define LCDC_FLASH_HALF_MS   250
`define LCDC_FLASH_HALF_CYC  (`LCDC_FLASH_HALF_MS * `LCDC_CLK_KHZ)

`endif

// ==== core/lcdc_pkg.sv ====
package lcdc_pkg;

  // Command interpreter states.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DISP   = 3'b001,
    ST_ADDR_L = 3'b010,
    ST_ADDR_H = 3'b011,
    ST_FORM_W = 3'b100,
    ST_FORM_H = 3'b101,
    ST_MEMORY_WRITE_COMMAND = 3'b110,
    ST_IGNORE = 3'b111
  } lcdc_state_e;

  // Cursor auto-advance directions.
  typedef enum logic [1:0] {
    DIR_RIGHT = 2'b00,
    DIR_LEFT  = 2'b01,
    DIR_UP    = 2'b10,
    DIR_DOWN  = 2'b11
  } lcdc_dir_e;

  // Cursor flash field encodings.
  typedef enum logic [1:0] {
    FLASH_OFF    = 2'b00,
    FLASH_STEADY = 2'b01,
    FLASH_2HZ    = 2'b10,
    FLASH_1HZ    = 2'b11
  } lcdc_flash_e;

endpackage

// ==== core/lcdc_cmd.sv ====
`timescale 1ns/10ps
`include "lcdc_defines.svh"

// Behaviour
// - 58h turns display off, 59h on.
// - Parameter bits 1-0 select cursor flash.
// - Parameter bits 3-2 gate block one.
// - Parameter bits 5-4 gate blocks two, four.
// - Parameter bits 7-6 gate block three.
// - 46h loads cursor address, low then high.
// - 5Dh first parameter nibble is width minus one.
// - Second parameter nibble is height minus one.
// - Second parameter bit 7 selects block cursor.
// - Direction command low bits set advance direction.
// - 42h writes bytes, cursor advances after each.

module lcdc_cmd #(
  parameter int unsigned FLASH_HALF_CYCLES = `LCDC_FLASH_HALF_CYC
) (
  input  wire logic        sys_clk_in,          // System clock, 20 MHz.
  input  wire logic        reset_n_in,          // Asynchronous reset, active low.
  input  wire logic [7:0]  host_data_in,        // Host data bus pins.
  input  wire logic        host_cmd_in,         // High marks a command byte.
  input  wire logic        host_wr_n_in,        // Host write strobe, active low.
  output logic             display_on_out,      // Display enable bit.
  output logic [1:0]       cursor_flash_out,    // Cursor flash field.
  output logic [1:0]       block_one_out,       // First screen block attribute.
  output logic [1:0]       block_two_four_out,  // Second and fourth block attribute.
  output logic [1:0]       block_three_out,     // Third screen block attribute.
  output logic [3:0]       cursor_width_out,    // Cursor width minus one.
  output logic [3:0]       cursor_height_out,   // Cursor height minus one.
  output logic             cursor_block_out,    // High for block cursor.
  output logic [1:0]       cursor_dir_out,      // Auto-advance direction.
  output logic [15:0]      cursor_addr_out,     // Current cursor address.
  output logic             cursor_visible_out,  // Cursor shown this instant.
  output logic             mem_we_out,          // Display memory write pulse.
  output logic [15:0]      mem_addr_out,        // Display memory write address.
  output logic [7:0]       mem_data_out         // Display memory write data.
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------

  logic [7:0] data_s1_reg;
  logic [7:0] data_s2_reg;
  logic       cmd_s1_reg;
  logic       cmd_s2_reg;
  logic       wr_s1_reg;
  logic       wr_s2_reg;
  logic       wr_s3_reg;
  logic       byte_strobe;
  logic [7:0] data_s1_next;
  logic [7:0] data_s2_next;
  logic       cmd_s1_next;
  logic       cmd_s2_next;
  logic       wr_s1_next;
  logic       wr_s2_next;
  logic       wr_s3_next;

  // Shifts each pin one stage further; the third strobe stage only feeds edge detection.
  // Logic reads only the second stage, since the first may still be settling.
  always_comb begin
    data_s1_next = host_data_in;
    data_s2_next = data_s1_reg;
    cmd_s1_next  = host_cmd_in;
    cmd_s2_next  = cmd_s1_reg;
    wr_s1_next   = host_wr_n_in;
    wr_s2_next   = wr_s1_reg;
    wr_s3_next   = wr_s2_reg;
  end

  // Registers the synchroniser stages.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_s1_reg <= 8'h00;
      data_s2_reg <= 8'h00;
      cmd_s1_reg  <= 1'b0;
      cmd_s2_reg  <= 1'b0;
      wr_s1_reg   <= 1'b1;
      wr_s2_reg   <= 1'b1;
      wr_s3_reg   <= 1'b1;
    end else begin
      data_s1_reg <= data_s1_next;
      data_s2_reg <= data_s2_next;
      cmd_s1_reg  <= cmd_s1_next;
      cmd_s2_reg  <= cmd_s2_next;
      wr_s1_reg   <= wr_s1_next;
      wr_s2_reg   <= wr_s2_next;
      wr_s3_reg   <= wr_s3_next;
    end
  end

  // A byte is taken when the synchronised strobe rises, the end of the write.
  // Taking it on release leaves the data pins the whole strobe low time to settle first.
  assign byte_strobe = wr_s2_reg & ~wr_s3_reg;

  // ----------------------------------------------------------------
  // Command interpreter
  // ----------------------------------------------------------------

  lcdc_pkg::lcdc_state_e state_reg;
  lcdc_pkg::lcdc_state_e state_next;
  logic [7:0]            disp_en_reg;
  logic [7:0]            disp_en_next;
  logic [7:0]            attr_reg;
  logic [7:0]            attr_next;
  logic [7:0]            width_reg;
  logic [7:0]            width_next;
  logic [7:0]            height_reg;
  logic [7:0]            height_next;
  logic [7:0]            dir_reg;
  logic [7:0]            dir_next;
  logic [15:0]           addr_reg;
  logic [15:0]           addr_next;
  logic                  we_reg;
  logic                  we_next;
  logic [15:0]           waddr_reg;
  logic [15:0]           waddr_next;
  logic [7:0]            wdata_reg;
  logic [7:0]            wdata_next;
  logic [15:0]           addr_step;

  // Address after one memory write, following the selected direction.
  always_comb begin
    case (lcdc_pkg::lcdc_dir_e'(dir_reg[1:0]))
      lcdc_pkg::DIR_RIGHT: addr_step = addr_reg + 16'h0001;
      lcdc_pkg::DIR_LEFT:  addr_step = addr_reg - 16'h0001;
      lcdc_pkg::DIR_UP:    addr_step = addr_reg - `LCDC_ROW_PITCH;
      lcdc_pkg::DIR_DOWN:  addr_step = addr_reg + `LCDC_ROW_PITCH;
      default:             addr_step = addr_reg;
    endcase
  end

  // Decodes command bytes and routes parameter bytes into registers.
  always_comb begin
    state_next   = state_reg;
    disp_en_next = disp_en_reg;
    attr_next    = attr_reg;
    width_next   = width_reg;
    height_next  = height_reg;
    dir_next     = dir_reg;
    addr_next    = addr_reg;
    // The memory write strobe lasts a single clock.
    we_next      = 1'b0;
    waddr_next   = waddr_reg;
    wdata_next   = wdata_reg;
    if (byte_strobe && cmd_s2_reg) begin
      // Any command byte closes the previous parameter stream.
      state_next = lcdc_pkg::ST_IGNORE;
      if (data_s2_reg == `LCDC_CMD_DISP_OFF || data_s2_reg == `LCDC_CMD_DISP_ON) begin
        disp_en_next[`LCDC_DISP_EN_BIT] = data_s2_reg[0];
        state_next = lcdc_pkg::ST_DISP;
      end else if (data_s2_reg == `LCDC_CMD_CSR_ADDR) begin
        state_next = lcdc_pkg::ST_ADDR_L;
      end else if (data_s2_reg == `LCDC_CMD_CURSOR_SHAPE_COMMAND) begin
        state_next = lcdc_pkg::ST_FORM_W;
      end else if ((data_s2_reg & `LCDC_CMD_DIR_MASK) == `LCDC_CMD_DIR_BASE) begin
        dir_next   = {6'h00, data_s2_reg[1:0]};
        state_next = lcdc_pkg::ST_IGNORE;
      end else if (data_s2_reg == `LCDC_CMD_MEM_WRITE) begin
        state_next = lcdc_pkg::ST_MEMORY_WRITE_COMMAND;
      end
    end else if (byte_strobe) begin
      case (state_reg)
        lcdc_pkg::ST_DISP: begin
          attr_next  = data_s2_reg;
          state_next = lcdc_pkg::ST_IGNORE;
        end
        lcdc_pkg::ST_ADDR_L: begin
          addr_next  = {addr_reg[15:8], data_s2_reg};
          state_next = lcdc_pkg::ST_ADDR_H;
        end
        lcdc_pkg::ST_ADDR_H: begin
          addr_next  = {data_s2_reg, addr_reg[7:0]};
          state_next = lcdc_pkg::ST_IGNORE;
        end
        lcdc_pkg::ST_FORM_W: begin
          width_next = {4'h0, data_s2_reg[3:0]};
          state_next = lcdc_pkg::ST_FORM_H;
        end
        lcdc_pkg::ST_FORM_H: begin
          height_next = {data_s2_reg[7], 3'h0, data_s2_reg[3:0]};
          state_next  = lcdc_pkg::ST_IGNORE;
        end
        lcdc_pkg::ST_MEMORY_WRITE_COMMAND: begin
          we_next    = 1'b1;
          waddr_next = addr_reg;
          wdata_next = data_s2_reg;
          addr_next  = addr_step;
        end
        // Parameters with no open command, or beyond its count, are dropped.
        lcdc_pkg::ST_IDLE,
        lcdc_pkg::ST_IGNORE: begin
          state_next = lcdc_pkg::ST_IGNORE;
        end
        default: begin
          state_next = lcdc_pkg::ST_IGNORE;
        end
      endcase
    end
  end

  // Registers the interpreter state and the command registers.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg   <= lcdc_pkg::ST_IDLE;
      disp_en_reg <= `LCDC_RESET_BYTE;
      attr_reg    <= `LCDC_RESET_BYTE;
      width_reg   <= `LCDC_RESET_BYTE;
      height_reg  <= `LCDC_RESET_BYTE;
      dir_reg     <= `LCDC_RESET_BYTE;
      addr_reg    <= `LCDC_RESET_ADDR;
      we_reg      <= 1'b0;
      waddr_reg   <= `LCDC_RESET_ADDR;
      wdata_reg   <= `LCDC_RESET_BYTE;
    end else begin
      state_reg   <= state_next;
      disp_en_reg <= disp_en_next;
      attr_reg    <= attr_next;
      width_reg   <= width_next;
      height_reg  <= height_next;
      dir_reg     <= dir_next;
      addr_reg    <= addr_next;
      we_reg      <= we_next;
      waddr_reg   <= waddr_next;
      wdata_reg   <= wdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Cursor flash timing
  // ----------------------------------------------------------------

  logic [31:0] flash_cnt_reg;
  logic [31:0] flash_cnt_next;
  logic        phase_fast_reg;
  logic        phase_fast_next;
  logic        phase_slow_reg;
  logic        phase_slow_next;
  logic        visible_reg;
  logic        visible_next;

  // Toggles the 2 Hz phase every half period; the slow phase halves it.
  always_comb begin
    flash_cnt_next  = flash_cnt_reg + 32'h1;
    phase_fast_next = phase_fast_reg;
    phase_slow_next = phase_slow_reg;
    if (flash_cnt_reg >= 32'(FLASH_HALF_CYCLES - 1)) begin
      flash_cnt_next  = 32'h0;
      phase_fast_next = ~phase_fast_reg;
      phase_slow_next = phase_slow_reg ^ phase_fast_reg;
    end
    case (lcdc_pkg::lcdc_flash_e'(attr_reg[`LCDC_FLASH_LSB +: 2]))
      lcdc_pkg::FLASH_OFF:    visible_next = 1'b0;
      lcdc_pkg::FLASH_STEADY: visible_next = 1'b1;
      lcdc_pkg::FLASH_2HZ:    visible_next = phase_fast_reg;
      lcdc_pkg::FLASH_1HZ:    visible_next = phase_slow_reg;
      default:                visible_next = 1'b0;
    endcase
    visible_next = visible_next & disp_en_reg[`LCDC_DISP_EN_BIT];
  end

  // Registers the flash counter, phases and visibility.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flash_cnt_reg  <= 32'h0;
      phase_fast_reg <= 1'b1;
      phase_slow_reg <= 1'b1;
      visible_reg    <= 1'b0;
    end else begin
      flash_cnt_reg  <= flash_cnt_next;
      phase_fast_reg <= phase_fast_next;
      phase_slow_reg <= phase_slow_next;
      visible_reg    <= visible_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Every output is a register or a fixed slice of one.
  assign display_on_out     = disp_en_reg[`LCDC_DISP_EN_BIT];
  assign cursor_flash_out   = attr_reg[`LCDC_FLASH_LSB +: 2];
  assign block_one_out      = attr_reg[`LCDC_BLK1_LSB +: 2];
  assign block_two_four_out = attr_reg[`LCDC_BLK24_LSB +: 2];
  assign block_three_out    = attr_reg[`LCDC_BLK3_LSB +: 2];
  assign cursor_width_out   = width_reg[3:0];
  assign cursor_height_out  = height_reg[3:0];
  assign cursor_block_out   = height_reg[`LCDC_SHAPE_BIT];
  assign cursor_dir_out     = dir_reg[1:0];
  assign cursor_addr_out    = addr_reg;
  assign cursor_visible_out = visible_reg;
  assign mem_we_out         = we_reg;
  assign mem_addr_out       = waddr_reg;
  assign mem_data_out       = wdata_reg;

endmodule

// ==== bench/lcdc_cmd_chk.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Output relations of the command decoder.
// ----------------------------------------
module lcdc_chk (
  input wire logic        sys_clk_in,         // Clock.
  input wire logic        reset_n_in,         // Reset, active low.
  input wire logic        host_wr_n_in,       // Write strobe.
  input wire logic        display_on_out,     // Display enable.
  input wire logic [1:0]  cursor_flash_out,   // Flash field.
  input wire logic [1:0]  cursor_dir_out,     // Direction.
  input wire logic [15:0] cursor_addr_out,    // Cursor address.
  input wire logic        cursor_visible_out, // Cursor shown.
  input wire logic [3:0]  cursor_width_out,   // Width minus one.
  input wire logic [3:0]  cursor_height_out,  // Height minus one.
  input wire logic        mem_we_out,         // Write pulse.
  input wire logic [15:0] mem_addr_out,       // Write address.
  input wire logic [7:0]  mem_data_out        // Write data.
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // A quiet strobe for eight cycles, and one memory write.
  sequence s_quiet; host_wr_n_in [*8]; endsequence
  sequence s_write; mem_we_out; endsequence
  property p_we_pulse; s_write |=> !mem_we_out [*5]; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write pulse too long");
  property p_hold; !mem_we_out |-> $stable(mem_data_out) && $stable(mem_addr_out); endproperty
  a_hold: assert property (p_hold) else $error("write bus moved");
  property p_quiet; s_quiet |-> $stable({display_on_out, cursor_flash_out, cursor_dir_out,
    cursor_addr_out, cursor_width_out, cursor_height_out}); endproperty
  a_quiet: assert property (p_quiet) else $error("state moved with no byte");
  property p_off; !display_on_out && !$past(display_on_out) |-> !cursor_visible_out; endproperty
  a_off: assert property (p_off) else $error("cursor shown while off");
  property p_noflash; (cursor_flash_out == 2'b00) [*2] |-> !cursor_visible_out; endproperty
  a_noflash: assert property (p_noflash) else $error("cursor shown with flash off");
  property p_steady; (display_on_out && cursor_flash_out == 2'b01) [*2] |-> cursor_visible_out;
  endproperty
  a_steady: assert property (p_steady) else $error("steady cursor hidden");
  property p_right;
    (s_write and (cursor_dir_out == 2'b00)) |-> cursor_addr_out == mem_addr_out + 16'h0001;
  endproperty
  a_right: assert property (p_right) else $error("right step wrong");
  property p_down;
    (s_write and (cursor_dir_out == 2'b11)) |-> cursor_addr_out == mem_addr_out + 16'h0080;
  endproperty
  a_down: assert property (p_down) else $error("down step wrong");
  property p_left;
    (s_write and (cursor_dir_out == 2'b01)) |-> cursor_addr_out == mem_addr_out - 16'h0001;
  endproperty
  a_left: assert property (p_left) else $error("left step wrong");
  property p_up;
    (s_write and (cursor_dir_out == 2'b10)) |-> cursor_addr_out == mem_addr_out - 16'h0080;
  endproperty
  a_up: assert property (p_up) else $error("up step wrong");
endmodule

bind lcdc_cmd lcdc_chk u_chk (.sys_clk_in, .reset_n_in, .host_wr_n_in, .display_on_out,
  .cursor_flash_out, .cursor_dir_out, .cursor_addr_out, .cursor_visible_out, .cursor_width_out,
  .cursor_height_out, .mem_we_out, .mem_addr_out, .mem_data_out);

// ==== bench/lcdc_host_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Host processor on the parallel command bus.
// ----------------------------------------
module lcdc_host_model (
  input  wire logic       sys_clk_in, // Clock.
  output logic [7:0]      data_out,   // Data pins.
  output logic            cmd_out,    // High for a command byte.
  output logic            wr_n_out    // Write strobe, active low.
);
  // The bus idles with the strobe high.
  initial begin
    data_out = 8'h00;
    cmd_out = 1'b0;
    wr_n_out = 1'b1;
  end
  // One byte: strobe low four cycles, hold four, then the bus no longer keeps its value.
  task automatic put(input logic c, input logic [7:0] b);
    @(negedge sys_clk_in);
    data_out = b;
    cmd_out = c;
    wr_n_out = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    wr_n_out = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    data_out = ~b;
    cmd_out = ~c;
  endtask
endmodule

// ==== bench/lcd_display_cursor_commands_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
// ----------------------------------------
// Self-checking bench of the command decoder.
// ----------------------------------------
module lcd_display_cursor_commands_tb_top;
  logic sys_clk, reset_n, disp, blk, vis, we;
  logic [1:0] flash, b1, b24, b3, dir;
  logic [3:0] wid, hgt;
  logic [15:0] caddr, maddr;
  logic [7:0] mdata, hd;
  logic hc, hw_n;
  logic [15:0] wa [$];
  logic [7:0] wd [$];
  int compares = 0;
  int fail_count = 0;
  int cycles = 0;
  lcdc_host_model h (.sys_clk_in(sys_clk), .data_out(hd), .cmd_out(hc), .wr_n_out(hw_n));
  lcdc_cmd #(.FLASH_HALF_CYCLES(8)) dut (.sys_clk_in(sys_clk), .reset_n_in(reset_n),
    .host_data_in(hd), .host_cmd_in(hc), .host_wr_n_in(hw_n), .display_on_out(disp),
    .cursor_flash_out(flash), .block_one_out(b1), .block_two_four_out(b24),
    .block_three_out(b3), .cursor_width_out(wid), .cursor_height_out(hgt),
    .cursor_block_out(blk), .cursor_dir_out(dir), .cursor_addr_out(caddr),
    .cursor_visible_out(vis), .mem_we_out(we), .mem_addr_out(maddr), .mem_data_out(mdata));
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;
  // Memory writes are logged at the falling edge, away from the register updates.
  always @(negedge sys_clk) begin
    if (we === 1'b1) begin
      wa.push_back(maddr);
      wd.push_back(mdata);
    end
  end
  // A hang is cut short well past the expected run length.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic send(input logic [7:0] c, input int n, input logic [7:0] p0, p1);
    h.put(1'b1, c);
    if (n > 0) h.put(1'b0, p0);
    if (n > 1) h.put(1'b0, p1);
  endtask
  task automatic settle();
    repeat (4) @(negedge sys_clk);
  endtask
  // Counts changes of the cursor visibility over a number of clocks.
  task automatic count_toggles(input int cyc, output int n);
    logic last;
    n = 0;
    last = vis;
    repeat (cyc) begin
      @(negedge sys_clk);
      if (vis !== last) n++;
      last = vis;
    end
  endtask
  // Configure with the display off, clear memory, shape the cursor, then switch on.
  task automatic t_init();
    send(8'h58, 1, 8'h56, 8'h00);
    settle();
    `CHK("disp", 1'b0, disp)
    `CHK("flash", 2'b10, flash)
    `CHK("blk1", 2'b01, b1)
    `CHK("blk24", 2'b01, b24)
    `CHK("blk3", 2'b01, b3)
    send(8'h46, 2, 8'h00, 8'h00);
    wa.delete();
    wd.delete();
    send(8'h42, 2, 8'h20, 8'h20);
    h.put(1'b0, 8'h20);
    settle();
    `CHK("wa2", 16'h0002, wa[2])
    `CHK("wd2", 8'h20, wd[2])
    send(8'h5D, 2, 8'h04, 8'h86);
    send(8'h59, 0, 8'h00, 8'h00);
    settle();
    `CHK("wid", 4'h4, wid)
    `CHK("hgt", 4'h6, hgt)
    `CHK("blk", 1'b1, blk)
    `CHK("disp", 1'b1, disp)
    `CHK("flash", 2'b10, flash)
    $display("TEST init done");
  endtask
  // Every direction code, each followed by two memory writes from 1001h.
  task automatic t_dir();
    logic [15:0] step [4] = '{16'h0001, 16'hFFFF, 16'hFF80, 16'h0080};
    for (int i = 0; i < 4; i++) begin
      send(8'h4C | 8'(i), 0, 8'h00, 8'h00);
      send(8'h46, 2, 8'h01, 8'h10);
      settle();
      `CHK("dir", 2'(i), dir)
      `CHK("addr", 16'h1001, caddr)
      wa.delete();
      send(8'h42, 2, 8'hFF, 8'hFF);
      settle();
      `CHK("wa1", 16'h1001 + step[i], wa[1])
      `CHK("caddr", 16'h1001 + step[i] + step[i], caddr)
    end
    $display("TEST dir done");
  endtask
  // A low byte alone, a write cut short by a command, then a stray parameter.
  task automatic t_abort();
    send(8'h46, 1, 8'h34, 8'h00);
    wa.delete();
    send(8'h42, 1, 8'hAA, 8'h00);
    send(8'h4C, 1, 8'h55, 8'h00);
    settle();
    `CHK("nwr", 1, wa.size())
    `CHK("wa0", 16'h1134, wa[0])
    `CHK("caddr", 16'h11B4, caddr)
    $display("TEST abort done");
  endtask
  // Steady, blinking at both rates, flash off with distinct block fields, display off.
  task automatic t_flash();
    int n;
    send(8'h59, 1, 8'h55, 8'h00);
    settle();
    `CHK("vis", 1'b1, vis)
    send(8'h59, 1, 8'h56, 8'h00);
    count_toggles(40, n);
    `CHK("blink", 1'b1, n >= 4 && n <= 6)
    send(8'h59, 1, 8'h57, 8'h00);
    count_toggles(40, n);
    `CHK("slow", 1'b1, n >= 2 && n <= 3)
    send(8'h59, 1, 8'hE4, 8'h00);
    settle();
    `CHK("flash", 2'b00, flash)
    `CHK("vis", 1'b0, vis)
    `CHK("blk1", 2'b01, b1)
    `CHK("blk24", 2'b10, b24)
    `CHK("blk3", 2'b11, b3)
    send(8'h59, 1, 8'h55, 8'h00);
    send(8'h58, 0, 8'h00, 8'h00);
    settle();
    `CHK("vis", 1'b0, vis)
    $display("TEST flash done");
  endtask
  // A reset in mid-run clears the outputs; a parameter with no command is dropped.
  task automatic t_reset();
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    `CHK("rdisp", 1'b0, disp)
    `CHK("rblk3", 2'b00, b3)
    `CHK("rwid", 4'h0, wid)
    `CHK("rcaddr", 16'h0000, caddr)
    wa.delete();
    h.put(1'b0, 8'h77);
    settle();
    `CHK("rnwr", 0, wa.size())
    `CHK("rflash", 2'b00, flash)
    send(8'h5D, 2, 8'h0F, 8'h03);
    settle();
    `CHK("wid", 4'hF, wid)
    `CHK("hgt", 4'h3, hgt)
    `CHK("blk", 1'b0, blk)
    $display("TEST reset done");
  endtask
  task automatic wrap_up();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Reset for eight cycles, then the scenarios in turn.
  initial begin
    reset_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    reset_n = 1'b1;
    t_init();
    t_dir();
    t_abort();
    t_flash();
    t_reset();
    wrap_up();
  end
endmodule
